/* File: common/cth_pkg.sv */
// Constants, field layouts and carrier types for the cyclic timer and high-side control block
package cth_pkg;

  // ------------------------------------------------------------
  // Register addresses (7-bit register address space)
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_TIMER_A = 7'h0C; // timer_a_control
  localparam logic [6:0] ADDR_TIMER_B = 7'h0D; // timer_b_control
  localparam logic [6:0] ADDR_SW_SD = 7'h10;   // switch_shutdown_control
  localparam logic [6:0] ADDR_HIGH_SIDE_CONTROL_ONE = 7'h14; // high_side_control_one

  // ------------------------------------------------------------
  // Reset values and writable-bit masks
  // ------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TIMER_MASK = 8'h77;  // Bits 7 and 3 reserved
  localparam logic [7:0] SD_MASK = 8'h70;     // Bits 7 and 3:0 reserved
  localparam logic [7:0] HS_MASK = 8'h77;     // Bits 7 and 3 reserved

  // ------------------------------------------------------------
  // Field codes
  // ------------------------------------------------------------
  localparam logic [2:0] ON_STOP_LOW = 3'h0;  // Timer stopped, output low
  localparam logic [2:0] ON_STOP_HIGH = 3'h6; // Timer stopped, output high
  localparam logic [2:0] ON_RSVD = 3'h7;
  localparam logic [2:0] PER_RSVD = 3'h7;
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_ON = 3'h1;
  localparam logic [2:0] SEL_TMR_A = 3'h2;
  localparam logic [2:0] SEL_TMR_B = 3'h3;
  localparam logic [2:0] SEL_PG_A = 3'h4;
  localparam logic [2:0] SEL_PG_B = 3'h5;

  // ------------------------------------------------------------
  // Timing: all timer figures are whole multiples of 0.1 ms ticks
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;        // 200 MHz core clock
  localparam int TICK_PS = 100000000;         // 0.1 ms
  localparam int TICK_CYCLES_DEF = TICK_PS / CLK_PERIOD_PS;
  localparam int TICK_W = 20;
  localparam int CNT_W = 16;
  // On-times in ticks: 0.1, 0.3, 1.0, 10, 20 ms
  localparam logic [15:0] ON_T_0P1MS = 16'h0001;
  localparam logic [15:0] ON_T_0P3MS = 16'h0003;
  localparam logic [15:0] ON_T_1MS = 16'h000A;
  localparam logic [15:0] ON_T_10MS = 16'h0064;
  localparam logic [15:0] ON_T_20MS = 16'h00C8;
  // Periods in ticks: 10, 20, 50, 100, 200 ms, 1 s, 2 s
  localparam logic [15:0] PER_T_10MS = 16'h0064;
  localparam logic [15:0] PER_T_20MS = 16'h00C8;
  localparam logic [15:0] PER_T_50MS = 16'h01F4;
  localparam logic [15:0] PER_T_100MS = 16'h03E8;
  localparam logic [15:0] PER_T_200MS = 16'h07D0;
  localparam logic [15:0] PER_T_1S = 16'h2710;
  localparam logic [15:0] PER_T_2S = 16'h4E20;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic rsv7;
    logic [2:0] on_time;
    logic rsv3;
    logic [2:0] period;
  } cth_tmr_ctrl_t;

  typedef struct packed {
    logic rsv7;
    logic overvoltage_shutdown_disable;
    logic undervoltage_shutdown_disable;
    logic supply_fault_recovery;
    logic [3:0] rsv;
  } cth_sd_ctrl_t;

  typedef struct packed {
    logic rsv7;
    logic [2:0] sw2;
    logic rsv3;
    logic [2:0] sw1;
  } cth_hs_ctrl_t;

  typedef struct packed {
    logic wr;          // One-cycle write strobe
    logic [6:0] addr;  // Register address, also selects read data
    logic [7:0] wdata; // Write data
  } cth_reg_req_t;

  typedef struct packed {
    logic [1:0] overtemp;   // Per switch, bit 0 = switch 1
    logic [1:0] overcurrent;
    logic supply_uv;
    logic supply_ov;
  } cth_fault_t;

  // Timer phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ON = 3'b010,
    PH_OFF = 3'b100
  } cth_phase_t;

endpackage

/* File: hw/cth_top.sv */
// Two cyclic timers, shutdown control and high-side switch control registers
// Functional notes
// RULE_01 - Timer A on-time codes select pulse widths
// RULE_02 - Code 110 stops timer holding output high
// RULE_03 - Timer period codes select 10 ms to 2 s
// RULE_04 - Timer B has identical fields and codes
// RULE_05 - Timer runs once assigned and on-time set
// RULE_06 - Restart switch clear also clears timer fields; the code clears them only while cyclic_sense_en is set
// RULE_07 - Cyclic sense and wake share one timer
// RULE_08 - Reserved bits always read as zero
// RULE_09 - Bit 6 set suppresses overvoltage shutdown
// RULE_10 - Bit 5 set suppresses undervoltage shutdown
// RULE_11 - Bit 4 restores prior switch state afterwards
// RULE_12 - Switch codes off, on, timer A, timer B
// RULE_13 - Codes 100/101 select pulse generators A/B
// RULE_14 - Overcurrent or overtemperature clears switch field
// RULE_15 - All registers zero on power-on, soft reset
// RULE_16 - Wake filter samples at on-time end
// RULE_17 - Hardware clears win over same-cycle writes
`timescale 1ns/100ps
`default_nettype none

module cth_top
  import cth_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF // Cycles per 0.1 ms tick
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  // Register access from the serial frame decoder
  input wire cth_reg_req_t reg_req,
  output logic [7:0] reg_rd_data,
  // Supply and switch faults from analog, asynchronous
  input wire cth_fault_t fault_in,
  // System state and pulse generators, same clock
  input wire logic restart_clear,
  input wire logic cyclic_sense_en,
  input wire logic pulse_gen_a,
  input wire logic pulse_gen_b,
  // Switch drive and timer outputs
  output logic high_side_switch_1,
  output logic high_side_switch_2,
  output logic [1:0] timer_level,
  output logic [1:0] timer_on_end
);

  // ------------------------------------------------------------
  // Decode functions
  // ------------------------------------------------------------

  // On-time code to ticks; zero for stopped or reserved codes
  function automatic logic [15:0] on_ticks(input logic [2:0] code);
    logic [15:0] t;
    unique case (code)
      3'h1: t = ON_T_0P1MS; // [RULE_01]
      3'h2: t = ON_T_0P3MS;
      3'h3: t = ON_T_1MS;
      3'h4: t = ON_T_10MS;
      3'h5: t = ON_T_20MS;
      default: t = '0;
    endcase
    return t;
  endfunction

  // Period code to ticks; zero for the reserved code
  function automatic logic [15:0] per_ticks(input logic [2:0] code);
    logic [15:0] t;
    unique case (code)
      3'h0: t = PER_T_10MS; // [RULE_03]
      3'h1: t = PER_T_20MS;
      3'h2: t = PER_T_50MS;
      3'h3: t = PER_T_100MS;
      3'h4: t = PER_T_200MS;
      3'h5: t = PER_T_1S;
      3'h6: t = PER_T_2S;
      default: t = '0;
    endcase
    return t;
  endfunction

  // Switch source selection; reserved codes keep the switch off
  function automatic logic sw_level(input logic [2:0] sel, input logic [1:0] tl,
                                    input logic pa, input logic pb);
    logic l;
    unique case (sel)
      SEL_ON: l = 1'b1;      // [RULE_12]
      SEL_TMR_A: l = tl[0];
      SEL_TMR_B: l = tl[1];
      SEL_PG_A: l = pa;      // [RULE_13]
      SEL_PG_B: l = pb;
      default: l = 1'b0;
    endcase
    return l;
  endfunction

  // Timer is in use when any switch selects it
  function automatic logic assigned(input cth_hs_ctrl_t hs, input logic [2:0] code);
    return (hs.sw1 == code) || (hs.sw2 == code);
  endfunction

  // ------------------------------------------------------------
  // Fault input synchronisers
  // ------------------------------------------------------------

  cth_fault_t sync1_q, sync2_q, sync3_q; // Three-stage chain
  cth_fault_t flt_q, flt_d;              // Accepted fault levels

  // Accept a change only once stages two and three agree
  always_comb begin
    flt_d = (sync2_q & sync3_q) | (flt_q & (sync2_q ^ sync3_q));
  end

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      flt_q <= '0;
    end else begin
      sync1_q <= fault_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      flt_q <= flt_d;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------

  cth_tmr_ctrl_t tmr_q [2];  // Timer A and B control
  cth_tmr_ctrl_t tmr_d [2];
  cth_sd_ctrl_t sd_q, sd_d;  // Shutdown control
  cth_hs_ctrl_t hs_q, hs_d;  // Switch control
  cth_hs_ctrl_t held_q, held_d; // Switch fields saved at supply fault
  logic shut_q, shut_d;      // Supply shutdown active last cycle
  logic shut_now;            // Supply shutdown requested this cycle
  logic [7:0] rd_d;          // Read data next value
  logic [7:0] rd_q;

  // Shutdown only acts when its disable bit is clear
  always_comb begin
    shut_now = (flt_q.supply_ov && !sd_q.overvoltage_shutdown_disable) // [RULE_09]
      || (flt_q.supply_uv && !sd_q.undervoltage_shutdown_disable);    // [RULE_10]
  end

  // Writes first, hardware clears after, so hardware wins a same-cycle race
  always_comb begin
    tmr_d = tmr_q;
    sd_d = sd_q;
    hs_d = hs_q;
    held_d = held_q;
    shut_d = shut_now;
    // Software writes, reserved bits masked off
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_TIMER_A: tmr_d[0] = cth_tmr_ctrl_t'(reg_req.wdata & TIMER_MASK); // [RULE_05]
        ADDR_TIMER_B: tmr_d[1] = cth_tmr_ctrl_t'(reg_req.wdata & TIMER_MASK); // [RULE_04]
        ADDR_SW_SD: sd_d = cth_sd_ctrl_t'(reg_req.wdata & SD_MASK);          // [RULE_08]
        ADDR_HIGH_SIDE_CONTROL_ONE: hs_d = cth_hs_ctrl_t'(reg_req.wdata & HS_MASK);
        default: ;
      endcase
    end
    // Supply fault onset: remember or drop the switch fields
    if (shut_now && !shut_q) begin
      if (sd_q.supply_fault_recovery) begin
        held_d = hs_d; // [RULE_11]
      end else begin
        hs_d.sw1 = SEL_OFF; // [RULE_11]
        hs_d.sw2 = SEL_OFF;
        held_d = '0;
      end
    end
    // Supply fault removal restores the saved fields
    if (!shut_now && shut_q && sd_q.supply_fault_recovery) begin
      hs_d = held_q; // [RULE_11]
    end
    // Per-switch overcurrent or overtemperature clears that field
    if (flt_q.overcurrent[0] || flt_q.overtemp[0]) begin
      hs_d.sw1 = SEL_OFF; // [RULE_14] [RULE_17]
      held_d.sw1 = SEL_OFF;
    end
    if (flt_q.overcurrent[1] || flt_q.overtemp[1]) begin
      hs_d.sw2 = SEL_OFF; // [RULE_14] [RULE_17]
      held_d.sw2 = SEL_OFF;
    end
    // Restart clear; timers follow when cyclic sensing is in use
    if (restart_clear) begin
      hs_d = '0;
      held_d = '0;
      if (cyclic_sense_en) begin
        tmr_d[0] = '0; // [RULE_06]
        tmr_d[1] = '0;
      end
    end
    // Soft reset returns everything to zero
    if (soft_reset) begin
      tmr_d[0] = REG_RESET; // [RULE_15]
      tmr_d[1] = REG_RESET;
      sd_d = REG_RESET;
      hs_d = REG_RESET;
      held_d = REG_RESET;
    end
    // Read mux, reserved bits are zero by construction
    unique case (reg_req.addr)
      ADDR_TIMER_A: rd_d = tmr_q[0]; // [RULE_08]
      ADDR_TIMER_B: rd_d = tmr_q[1];
      ADDR_SW_SD: rd_d = sd_q;
      ADDR_HIGH_SIDE_CONTROL_ONE: rd_d = hs_q;
      default: rd_d = '0;
    endcase
  end

  // Register stage for control state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_q[0] <= REG_RESET; // [RULE_15]
      tmr_q[1] <= REG_RESET;
      sd_q <= REG_RESET;
      hs_q <= REG_RESET;
      held_q <= REG_RESET;
      shut_q <= 1'b0;
      rd_q <= REG_RESET;
    end else begin
      tmr_q <= tmr_d;
      sd_q <= sd_d;
      hs_q <= hs_d;
      held_q <= held_d;
      shut_q <= shut_d;
      rd_q <= rd_d;
    end
  end

  // ------------------------------------------------------------
  // Tick prescaler and cyclic timers
  // ------------------------------------------------------------

  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d; // Cycles within a tick
  logic tick;                                // One-cycle tick pulse
  cth_phase_t phase_q [2];
  cth_phase_t phase_d [2];
  logic [CNT_W-1:0] cnt_q [2]; // Ticks elapsed in the period
  logic [CNT_W-1:0] cnt_d [2];
  logic [1:0] lvl_q, lvl_d;    // Timer output levels
  logic [1:0] end_q, end_d;    // On-time end pulses

  // One pulse and one prescaler serve both timers, so both count on the same ticks; each starts its own period when enabled
  always_comb begin
    tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? '0 : tick_cnt_q + TICK_W'(1);
  end

  // Each timer free-runs while assigned with a running on-time code and a non-reserved period code
  always_comb begin
    logic run;
    logic [CNT_W-1:0] nxt;
    run = 1'b0;
    nxt = '0;
    for (int i = 0; i < 2; i++) begin
      phase_d[i] = phase_q[i];
      cnt_d[i] = cnt_q[i];
      end_d[i] = 1'b0;
      run = assigned(hs_q, i[0] ? SEL_TMR_B : SEL_TMR_A) // [RULE_05]
        && (on_ticks(tmr_q[i].on_time) != '0)
        && (tmr_q[i].period != PER_RSVD);                 // [RULE_03]
      nxt = cnt_q[i] + CNT_W'(1);
      if (!run) begin
        phase_d[i] = PH_IDLE;
        cnt_d[i] = '0;
      end else if (phase_q[i] == PH_IDLE) begin
        phase_d[i] = PH_ON; // Starts on the first cycle it is enabled
      end else if (tick) begin
        if (nxt >= per_ticks(tmr_q[i].period)) begin
          cnt_d[i] = '0;
          phase_d[i] = PH_ON;
        end else begin
          cnt_d[i] = nxt;
          if (nxt >= on_ticks(tmr_q[i].on_time)) begin
            phase_d[i] = PH_OFF;
          end
        end
        // Same pulse feeds wake sampling and cyclic sensing alike
        end_d[i] = (phase_q[i] == PH_ON) && (phase_d[i] == PH_OFF); // [RULE_07] [RULE_16]
      end
      // Stopped timers hold low or high as the on-time code says
      lvl_d[i] = run ? (phase_d[i] == PH_ON)                   // [RULE_01]
                     : (tmr_q[i].on_time == ON_STOP_HIGH);      // [RULE_02]
    end
  end

  // Register stage for the timers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
      phase_q[0] <= PH_IDLE;
      phase_q[1] <= PH_IDLE;
      cnt_q[0] <= '0;
      cnt_q[1] <= '0;
      lvl_q <= '0;
      end_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      end_q <= end_d;
    end
  end

  // ------------------------------------------------------------
  // Switch drive
  // ------------------------------------------------------------

  logic [1:0] hs_out_q, hs_out_d;

  // Supply shutdown overrides every source; fields are left for recovery only when bit 4 is set
  always_comb begin
    hs_out_d[0] = !shut_now && sw_level(hs_q.sw1, lvl_q, pulse_gen_a, pulse_gen_b); // [RULE_12]
    hs_out_d[1] = !shut_now && sw_level(hs_q.sw2, lvl_q, pulse_gen_a, pulse_gen_b); // [RULE_13]
  end

  // Register stage for the switch drive
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_out_q <= '0;
    end else begin
      hs_out_q <= hs_out_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------

  assign reg_rd_data = rd_q;
  assign high_side_switch_1 = hs_out_q[0];
  assign high_side_switch_2 = hs_out_q[1];
  assign timer_level = lvl_q;
  assign timer_on_end = end_q;

endmodule

`default_nettype wire

/* File: bench/cth_top_props.sv */
// Port-level checker for the cyclic timer and high-side control block
`timescale 1ns/100ps
`default_nettype none

module cth_top_props
  import cth_pkg::*;
#(
  parameter int TICK_CYCLES = 4 // Cycles per tick, handed on from the design
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  // Register access
  input wire cth_reg_req_t reg_req,
  input wire logic [7:0] reg_rd_data,
  // Faults, system state and pulse generators
  input wire cth_fault_t fault_in,
  input wire logic restart_clear,
  input wire logic cyclic_sense_en,
  input wire logic pulse_gen_a,
  input wire logic pulse_gen_b,
  // Switch drive and timer outputs
  input wire logic high_side_switch_1,
  input wire logic high_side_switch_2,
  input wire logic [1:0] timer_level,
  input wire logic [1:0] timer_on_end
);
  // ------------------------------------------------------------
  // Quiet-fault counter
  // ------------------------------------------------------------
  logic [3:0] quiet_d; // Next count
  logic [3:0] quiet_q; // Cycles since any fault input was active
  logic quiet; // Fault filter has surely settled clear
  // Saturates so a long quiet spell never wraps back to zero
  always_comb begin
    quiet_d = (fault_in != '0) ? 4'h0 : ((quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1);
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_q <= 4'h0;
    end else begin
      quiet_q <= quiet_d;
    end
  end
  // Margin over the three-stage filter and the recovery restore
  assign quiet = (quiet_q > 4'h8);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_rsvd_ctrl: assert property (
    (reg_req.addr == ADDR_TIMER_A || reg_req.addr == ADDR_TIMER_B
      || reg_req.addr == ADDR_HIGH_SIDE_CONTROL_ONE) |=> (reg_rd_data & ~TIMER_MASK) == 8'h00)
    else $error("reserved bit set in timer or switch read");
  chk_rsvd_shut: assert property (
    (reg_req.addr == ADDR_SW_SD) |=> (reg_rd_data & ~SD_MASK) == 8'h00)
    else $error("reserved bit set in shutdown read");
  chk_switch_on: assert property (
    (reg_req.wr && reg_req.addr == ADDR_HIGH_SIDE_CONTROL_ONE && reg_req.wdata[2:0] == SEL_ON && quiet
      && !soft_reset && !restart_clear)
      ##1 (quiet && !soft_reset && !restart_clear && !reg_req.wr) |=> high_side_switch_1)
    else $error("switch 1 not on two edges after on code");
  chk_switch_off: assert property (
    (reg_req.wr && reg_req.addr == ADDR_HIGH_SIDE_CONTROL_ONE && reg_req.wdata[6:4] == SEL_OFF && quiet)
      |=> ##1 !high_side_switch_2)
    else $error("switch 2 not off two edges after off code");
  chk_pulse_follow: assert property (
    (reg_req.addr == ADDR_HIGH_SIDE_CONTROL_ONE && quiet) ##1 (reg_rd_data[2:0] == SEL_PG_A)
      |-> high_side_switch_1 == $past(pulse_gen_a))
    else $error("switch 1 does not follow pulse generator a");
  chk_end_a: assert property (
    timer_on_end[0] |-> ##[0:1] !timer_level[0] ##1 !timer_on_end[0])
    else $error("timer a end pulse malformed");
  chk_end_b: assert property (
    $rose(timer_on_end[1]) |=> $fell(timer_on_end[1]))
    else $error("timer b end pulse longer than one cycle");
  chk_soft_zero: assert property (
    soft_reset |-> ##2 (reg_rd_data == 8'h00 && !high_side_switch_1 && !high_side_switch_2))
    else $error("soft reset left a register or switch set");
  chk_oc_clear: assert property (
    fault_in.overcurrent[0] [*6] |=> !high_side_switch_1)
    else $error("switch 1 still on during overcurrent");
endmodule

bind cth_top cth_top_props #(.TICK_CYCLES(TICK_CYCLES)) i_cth_top_props (
  .core_clk(core_clk), .rst_b(rst_b), .soft_reset(soft_reset), .reg_req(reg_req),
  .reg_rd_data(reg_rd_data), .fault_in(fault_in), .restart_clear(restart_clear),
  .cyclic_sense_en(cyclic_sense_en), .pulse_gen_a(pulse_gen_a), .pulse_gen_b(pulse_gen_b),
  .high_side_switch_1(high_side_switch_1), .high_side_switch_2(high_side_switch_2),
  .timer_level(timer_level), .timer_on_end(timer_on_end));

`default_nettype wire

/* File: bench/cth_host_model.sv */
// Microcontroller model issuing register writes and reads to the block
`timescale 1ns/100ps
`default_nettype none

module cth_host_model
  import cth_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Register access
  output var cth_reg_req_t reg_req,
  input wire logic [7:0] reg_rd_data
);
  // Idle bus from time zero
  initial begin
    reg_req = '0;
  end
  // One-cycle strobe; data is scrambled after release so stale values never match
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge core_clk);
    reg_req.wr = 1'b0;
    reg_req.wdata = ~d;
  endtask
  // Read data is registered, so it is taken two falling edges after the address
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_req.addr = a;
    @(negedge core_clk);
    @(negedge core_clk);
    d = reg_rd_data;
  endtask
endmodule

`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking testbench for the cyclic timer and high-side control block
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import cth_pkg::*;
;
  localparam int TK = 4; // Shortened tick keeps the slow periods affordable
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic soft_reset = 1'b0;
  logic restart_clear = 1'b0;
  logic cyclic_sense_en = 1'b0;
  logic pulse_gen_a = 1'b0;
  logic pulse_gen_b = 1'b0;
  cth_fault_t fault_in = '0;
  cth_reg_req_t reg_req;
  logic [7:0] reg_rd_data;
  logic high_side_switch_1;
  logic high_side_switch_2;
  logic [1:0] timer_level;
  logic [1:0] timer_on_end;
  logic [6:0] addrs [5] = '{ADDR_TIMER_A, ADDR_TIMER_B, ADDR_SW_SD, ADDR_HIGH_SIDE_CONTROL_ONE, 7'h11};
  logic [7:0] masks [5] = '{TIMER_MASK, TIMER_MASK, SD_MASK, HS_MASK, 8'h00};
  logic [2:0] tper [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4}; // Period codes per step
  int on_tk [5] = '{1, 3, 10, 100, 200}; // Ticks for on codes 1 to 5
  int per_tk [5] = '{100, 200, 500, 1000, 2000};
  logic [7:0] sd_v [5] = '{8'h00, 8'h10, 8'h40, 8'h20, 8'h00};
  logic [4:0] uv_s = 5'b11000; // Undervoltage steps, others overvoltage
  logic [4:0] on_d = 5'b01100; // Switches on during the supply fault
  logic [4:0] on_a = 5'b01110; // Switches on after the fault clears
  int fails = 0;
  int check_count = 0;
  logic [7:0] rv;
  int n;
  int h;
  int t;
  logic e;

  always #2.5 core_clk = ~core_clk;

  cth_top #(.TICK_CYCLES(TK)) i_cth_top (.core_clk(core_clk), .rst_b(rst_b),
    .soft_reset(soft_reset), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .fault_in(fault_in), .restart_clear(restart_clear), .cyclic_sense_en(cyclic_sense_en),
    .pulse_gen_a(pulse_gen_a), .pulse_gen_b(pulse_gen_b),
    .high_side_switch_1(high_side_switch_1), .high_side_switch_2(high_side_switch_2),
    .timer_level(timer_level), .timer_on_end(timer_on_end));
  cth_host_model i_cth_host_model (.core_clk(core_clk), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    i_cth_host_model.rd(a, rv);
    check({8'h00, rv}, {8'h00, exp});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic pulse_rc();
    @(negedge core_clk);
    restart_clear = 1'b1;
    @(negedge core_clk);
    restart_clear = 1'b0;
  endtask
  task automatic print_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    cyc(5);
    rst_b = 1'b1;
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    foreach (addrs[i]) begin
      i_cth_host_model.wr(addrs[i], 8'hFF);
      rd_chk(addrs[i], masks[i]);
    end
    // Soft reset clears everything written above
    @(negedge core_clk);
    soft_reset = 1'b1;
    @(negedge core_clk);
    soft_reset = 1'b0;
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    // Every switch code on both fields, with the generators swapped
    for (int p = 0; p < 2; p++) begin
      pulse_gen_a = (p == 0);
      pulse_gen_b = (p == 1);
      for (int c = 0; c < 8; c++) begin
        i_cth_host_model.wr(ADDR_HIGH_SIDE_CONTROL_ONE, {1'b0, 3'(c), 1'b0, 3'(c)});
        cyc(3);
        e = (c == 1) || (c == 4 && pulse_gen_a) || (c == 5 && pulse_gen_b);
        check({14'h0, high_side_switch_2, high_side_switch_1}, {14'h0, e, e});
      end
    end
    // Timers alternate; each is assigned first and starts once its on-time is written
    for (int i = 0; i < 5; i++) begin
      t = i % 2;
      i_cth_host_model.wr(ADDR_HIGH_SIDE_CONTROL_ONE, (t == 1) ? 8'h30 : 8'h02);
      i_cth_host_model.wr(ADDR_TIMER_A + 7'(t), {5'h00, tper[i]});
      cyc(3 * TK);
      check({14'h0, timer_level}, 16'h0000);
      i_cth_host_model.wr(ADDR_TIMER_A + 7'(t), {1'b0, 3'(i + 1), 1'b0, tper[i]});
      n = 0;
      while (timer_on_end[t] !== 1'b1 && n < 9000) begin
        @(negedge core_clk);
        n++;
      end
      n = 0;
      h = 0;
      do begin
        @(negedge core_clk);
        n++;
        h += int'(timer_level[t]);
      end while (timer_on_end[t] !== 1'b1 && n < 9000);
      check(16'(n), 16'(per_tk[i] * TK));
      check(16'(h), 16'(on_tk[i] * TK));
    end
    // Reserved codes keep an assigned timer low; stopped high drives its switch on
    i_cth_host_model.wr(ADDR_TIMER_A, 8'h17);
    cyc(3 * TK);
    check({14'h0, timer_level}, 16'h0000);
    i_cth_host_model.wr(ADDR_TIMER_A, 8'h70);
    cyc(3 * TK);
    check({14'h0, timer_level}, 16'h0000);
    i_cth_host_model.wr(ADDR_TIMER_A, 8'h60);
    i_cth_host_model.wr(ADDR_HIGH_SIDE_CONTROL_ONE, 8'h02);
    cyc(4);
    check({15'h0, high_side_switch_1}, 16'h0001);
    // Restart clear wins over a same-cycle write; timers kept without cyclic sensing
    fork
      i_cth_host_model.wr(ADDR_HIGH_SIDE_CONTROL_ONE, 8'h12);
      pulse_rc();
    join
    rd_chk(ADDR_HIGH_SIDE_CONTROL_ONE, 8'h00);
    rd_chk(ADDR_TIMER_A, 8'h60);
    cyclic_sense_en = 1'b1;
    pulse_rc();
    rd_chk(ADDR_TIMER_A, 8'h00);
    cyclic_sense_en = 1'b0;
    // Per-switch faults clear only their own field
    i_cth_host_model.wr(ADDR_HIGH_SIDE_CONTROL_ONE, 8'h11);
    fault_in.overcurrent = 2'b01;
    cyc(10);
    rd_chk(ADDR_HIGH_SIDE_CONTROL_ONE, 8'h10);
    fault_in.overcurrent = 2'b00;
    fault_in.overtemp = 2'b10;
    cyc(10);
    rd_chk(ADDR_HIGH_SIDE_CONTROL_ONE, 8'h00);
    fault_in = '0;
    cyc(12);
    // Supply faults under each shutdown and recovery setting
    for (int i = 0; i < 5; i++) begin
      i_cth_host_model.wr(ADDR_SW_SD, sd_v[i]);
      i_cth_host_model.wr(ADDR_HIGH_SIDE_CONTROL_ONE, 8'h11);
      fault_in.supply_uv = uv_s[i];
      fault_in.supply_ov = !uv_s[i];
      cyc(10);
      check({14'h0, high_side_switch_2, high_side_switch_1}, {14'h0, {2{on_d[i]}}});
      fault_in = '0;
      cyc(12);
      check({14'h0, high_side_switch_2, high_side_switch_1}, {14'h0, {2{on_a[i]}}});
    end
    print_verdict();
  end

  // Watchdog: the sequence needs about 17k cycles, this allows 100k
  initial begin
    #500000;
    fails++;
    print_verdict();
  end
endmodule

`default_nettype wire
